// ==== fec_flash_eeprom_ctrl.sv ====
// Flash controller emulating an EEPROM by page swap and programming program flash
// What this block does
// - Four-byte cache forms new data words, not copies or status.
// - Byte mode merges written byte with flash word.
// - Cache bytes via data port or aliases.
// - Last two page bytes hold status only.
// - Erase swap, copy lead, data, trail.
// - Status written last, making swap current.
// - Each emulated page uses two flash pages.
// - Continuous mode writes swap directly, no copy.
// - Final non-continuous write copies and updates status.
// - Program writes whole words, ignore bits 1:0.
// - Program flash: 1K page erase, words only.
// - No continuous mode for program flash.
// - Address bits 14:10 select erased page.
// - Operation 1X01 selects program page erase.
// - Arm then go within four cycles starts.
// - Address register gives target and page.
// - Stall processor while go operation runs; reads do not.
// - Mode 000 byte, 010 word.
// - Read data valid within two cycles.
// - Emulated write erases swap automatically.
`timescale 1ns/100ps
module fec_flash_eeprom_ctrl
    import fec_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic [12:0] fl_addr,
    output logic [31:0] fl_wdata,
    output logic fl_rd,
    output logic fl_wr,
    output logic fl_erase,
    input wire logic [31:0] fl_rdata,
    input wire logic fl_done,
    output logic cpu_stall
);
    fec_cache_if cif();
    fec_word_cache u_cache (.mclk(mclk), .rstn(rstn), .cif(cif));

    logic [15:0] addr_q;
    logic [7:0] cfg_q;
    logic [3:0] op_q;
    logic [2:0] arm_cnt_q;
    logic go_q;
    logic [7:0] rdata_q;
    logic [7:0] rd_mux;
    fec_state_t state_q, state_d, ret_q, ret_d;
    fec_job_t job_q, job_d;
    logic [12:0] fa_q, fa_d;
    logic [31:0] fd_q, fd_d, hold_q, hold_d;
    logic [7:0] idx_q, idx_d, tgt_q, tgt_d;
    logic [1:0] pair_q, pair_d;
    logic [3:0] sel_q, sel_d;
    logic byte_q, byte_d, cont_q, cont_d, cerased_q, cerased_d;

    // Register port decode
    wire cmd_wr = reg_wr && (reg_addr == REG_CMD);
    wire go_wr = cmd_wr && reg_wdata[CMD_GO_BIT];
    wire arm_wr = cmd_wr && reg_wdata[CMD_ARM_BIT] && !reg_wdata[CMD_GO_BIT];
    wire arm_live = (arm_cnt_q != 3'h0);
    wire data_wr = reg_wr && (reg_addr == REG_DATA);
    wire cache_sel = (reg_addr >= REG_CACHE0) && (reg_addr <= REG_CACHE3);
    wire cache_wr = reg_wr && cache_sel;
    wire [3:0] cache_off = reg_addr - REG_CACHE0;
    wire [3:0] wop = reg_wdata[3:0];
    wire op_byte = (wop[3:1] == OP_MODE_BYTE);
    wire op_word = (wop[3:1] == OP_MODE_WORD);
    wire op_perase = wop[3] && (wop[1:0] == OP_PF_ERASE);
    wire op_pprog = wop[3] && (wop[1:0] == OP_PF_PROG);

    // address register splits into pair and word
    wire [1:0] a_pair = addr_q[11:10];
    wire [7:0] a_word = addr_q[9:2];
    wire pair_ok = (a_pair <= cfg_q[CFG_SIZE_LSB +: 2]);
    wire rsvd_byte = op_byte && (a_word == WORD_LAST) && addr_q[1];
    wire emu_ok = (op_byte || op_word) && pair_ok && !rsvd_byte;
    wire idle = (state_q == ST_IDLE);
    // go counts only inside the arm window
    wire start_go = idle && go_wr && arm_live && (emu_ok || op_perase || op_pprog);
    wire start_rd = idle && cmd_wr && reg_wdata[CMD_RG_BIT] && !reg_wdata[CMD_GO_BIT]
                    && (op_byte || op_word) && pair_ok;
    wire rd_busy = (state_q == ST_READ) || (state_q == ST_RD_CAP);
    wire busy = !idle && !rd_busy;

    // two flash pages per emulated page
    wire [4:0] a_cur_pg = EMU_BASE_PAGE + {2'b00, a_pair, sel_q[a_pair]};
    wire [4:0] cur_pg = EMU_BASE_PAGE + {2'b00, pair_q, sel_q[pair_q]};
    wire [4:0] swp_pg = EMU_BASE_PAGE + {2'b00, pair_q, ~sel_q[pair_q]};
    wire [1:0] pair_nx = pair_q + 2'h1;
    wire idx_last = (idx_q == WORD_LAST);
    wire copy_on = (idx_q < tgt_q) ? cfg_q[CFG_LEAD_BIT] : cfg_q[CFG_TRAIL_BIT];
    wire [31:0] cache_word = cif.word_q;
    // user data never reaches the status half
    wire [31:0] tgt_word = idx_last ? {HALF_ONES, cache_word[15:0]} : cache_word;
    wire [31:0] rd_masked = (fa_q[7:0] == WORD_LAST) ? {HALF_ONES, fl_rdata[15:0]} : fl_rdata;

    assign cif.word_we = (state_q == ST_MRG_CAP) || (state_q == ST_RD_CAP);
    // merge keeps the byte software wrote
    assign cif.word_be = (state_q == ST_MRG_CAP) ? ~(4'h1 << addr_q[1:0]) : 4'hF;
    assign cif.word_wd = rd_masked;
    // data port indexed by address, or direct aliases
    assign cif.byte_we = data_wr || cache_wr;
    assign cif.byte_idx = data_wr ? addr_q[1:0] : cache_off[1:0];
    assign cif.byte_wd = reg_wdata;

    wire [1:0] rd_lane = (reg_addr == REG_DATA) ? addr_q[1:0] : cache_off[1:0];
    wire [7:0] cache_byte = cache_word[8*rd_lane +: 8];
    wire [7:0] cmd_rd = {1'b0, rd_busy, go_q, arm_live, op_q};
    wire [7:0] stat_rd = {busy, (state_q > ST_BOOT_CHK), 2'b00, sel_q};

    always_comb
    begin
        case (reg_addr)
            REG_ADDR_LO: rd_mux = addr_q[7:0];
            REG_ADDR_HI: rd_mux = addr_q[15:8];
            REG_CMD: rd_mux = cmd_rd;
            REG_CFG: rd_mux = cfg_q;
            REG_STAT: rd_mux = stat_rd;
            default: rd_mux = (cache_sel || (reg_addr == REG_DATA)) ? cache_byte : 8'h00;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            addr_q <= ADDR_RST;
            cfg_q <= CFG_RST;
            op_q <= OP_RST;
            rdata_q <= 8'h00;
        end
        else
        begin
            if (reg_wr && (reg_addr == REG_ADDR_LO))
                addr_q[7:0] <= reg_wdata;
            if (reg_wr && (reg_addr == REG_ADDR_HI))
                addr_q[15:8] <= reg_wdata;
            if (reg_wr && (reg_addr == REG_CFG))
                cfg_q <= reg_wdata;
            if (cmd_wr)
                op_q <= wop;
            rdata_q <= reg_rd ? rd_mux : 8'h00;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            arm_cnt_q <= 3'h0;
            go_q <= 1'b0;
        end
        else
        begin
            if (arm_wr)
                arm_cnt_q <= ARM_CYCLES;
            else if (go_wr || !arm_live)
                arm_cnt_q <= 3'h0;
            else
                arm_cnt_q <= arm_cnt_q - 3'h1;
            // go drops when the operation ends
            if (start_go)
                go_q <= 1'b1;
            else if (state_q == ST_DONE)
                go_q <= 1'b0;
        end
    end

    always_comb
    begin
        state_d = state_q;
        ret_d = ret_q;
        job_d = job_q;
        fa_d = fa_q;
        fd_d = fd_q;
        hold_d = hold_q;
        idx_d = idx_q;
        tgt_d = tgt_q;
        pair_d = pair_q;
        sel_d = sel_q;
        byte_d = byte_q;
        cont_d = cont_q;
        cerased_d = cerased_q;
        case (state_q)
            ST_BOOT_RD: state_d = ST_BOOT_CHK;
            ST_BOOT_CHK:
            begin
                sel_d[pair_q] = (fl_rdata[31:16] != STAT_VALID);
                pair_d = pair_nx;
                fa_d = {EMU_BASE_PAGE + {2'b00, pair_nx, 1'b0}, WORD_LAST};
                state_d = (pair_q == 2'h3) ? ST_IDLE : ST_BOOT_RD;
            end
            ST_IDLE:
            begin
                if (start_rd)
                begin
                    fa_d = {a_cur_pg, a_word};
                    state_d = ST_READ;
                end
                else if (start_go && op_perase)
                begin
                    // page from bits 14:10, whole 1K page
                    job_d = JOB_PF;
                    fa_d = {addr_q[14:10], WORD_FIRST};
                    ret_d = ST_DONE;
                    state_d = ST_ERASE;
                end
                else if (start_go && op_pprog)
                begin
                    // word address, bits 1:0 dropped, one word per start
                    job_d = JOB_PF;
                    fa_d = addr_q[14:2];
                    fd_d = cache_word;
                    ret_d = ST_DONE;
                    state_d = ST_PROG;
                end
                else if (start_go)
                begin
                    job_d = JOB_EMU;
                    pair_d = a_pair;
                    tgt_d = a_word;
                    byte_d = op_byte;
                    cont_d = cfg_q[CFG_CONT_BIT];
                    state_d = ST_EMU_GO;
                end
            end
            ST_EMU_GO:
            begin
                // continuous mode visits the target word only
                idx_d = cont_q ? tgt_q : WORD_FIRST;
                if (byte_q)
                begin
                    fa_d = {cur_pg, tgt_q};
                    state_d = ST_MRG_RD;
                end
                else if (cerased_q)
                    state_d = ST_CP_SEL;
                else
                begin
                    // swap page erased without a command
                    fa_d = {swp_pg, WORD_FIRST};
                    ret_d = ST_CP_SEL;
                    cerased_d = cont_q;
                    state_d = ST_ERASE;
                end
            end
            ST_MRG_RD: state_d = ST_MRG_CAP;
            ST_MRG_CAP:
            begin
                byte_d = 1'b0;
                state_d = ST_EMU_GO;
            end
            ST_CP_SEL:
            begin
                // walk lead region, new data, trail region
                if (idx_q == tgt_q)
                begin
                    fa_d = {swp_pg, idx_q};
                    fd_d = tgt_word;
                    ret_d = ST_CP_NEXT;
                    state_d = ST_PROG;
                end
                else if (copy_on)
                begin
                    fa_d = {cur_pg, idx_q};
                    state_d = ST_CP_RD1;
                end
                else
                    state_d = ST_CP_NEXT;
            end
            ST_CP_RD1:
            begin
                fa_d = {swp_pg, idx_q};
                state_d = ST_CP_RD2;
            end
            ST_CP_RD2:
            begin
                hold_d = rd_masked;
                state_d = ST_CP_CHK;
            end
            ST_CP_CHK:
            begin
                // Words already written during a continuous run are kept
                if ((fl_rdata == WORD_ONES) && (hold_q != WORD_ONES))
                begin
                    fd_d = hold_q;
                    ret_d = ST_CP_NEXT;
                    state_d = ST_PROG;
                end
                else
                    state_d = ST_CP_NEXT;
            end
            ST_CP_NEXT:
            begin
                if (cont_q)
                    state_d = ST_DONE;
                else if (idx_last)
                begin
                    // new status only after the trail copy
                    fa_d = {swp_pg, WORD_LAST};
                    fd_d = {STAT_VALID, HALF_ONES};
                    ret_d = ST_RETIRE;
                    state_d = ST_PROG;
                end
                else
                begin
                    idx_d = idx_q + 8'h01;
                    state_d = ST_CP_SEL;
                end
            end
            ST_RETIRE:
            begin
                fa_d = {cur_pg, WORD_LAST};
                fd_d = {STAT_RETIRED, HALF_ONES};
                sel_d[pair_q] = ~sel_q[pair_q];
                ret_d = ST_DONE;
                state_d = ST_PROG;
            end
            ST_PROG: state_d = ST_WAIT;
            ST_ERASE: state_d = ST_WAIT;
            ST_WAIT: state_d = fl_done ? ret_q : ST_WAIT;
            ST_DONE:
            begin
                // the final non-continuous write closes the run
                if ((job_q == JOB_EMU) && !cont_q)
                    cerased_d = 1'b0;
                state_d = ST_IDLE;
            end
            ST_READ: state_d = ST_RD_CAP;
            ST_RD_CAP: state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            state_q <= ST_BOOT_RD;
            ret_q <= ST_IDLE;
            job_q <= JOB_EMU;
            fa_q <= {EMU_BASE_PAGE, WORD_LAST};
            fd_q <= WORD_ONES;
            hold_q <= WORD_ONES;
            {idx_q, tgt_q, pair_q, sel_q} <= 22'h000000;
            {byte_q, cont_q, cerased_q} <= 3'h0;
        end
        else
        begin
            state_q <= state_d;
            ret_q <= ret_d;
            job_q <= job_d;
            fa_q <= fa_d;
            fd_q <= fd_d;
            hold_q <= hold_d;
            {idx_q, tgt_q, pair_q, sel_q} <= {idx_d, tgt_d, pair_d, sel_d};
            {byte_q, cont_q, cerased_q} <= {byte_d, cont_d, cerased_d};
        end
    end

    assign reg_rdata = rdata_q;
    assign fl_addr = fa_q;
    assign fl_wdata = fd_q;
    assign fl_rd = (state_q == ST_BOOT_RD) || (state_q == ST_MRG_RD) || (state_q == ST_CP_RD1)
                   || (state_q == ST_CP_RD2) || (state_q == ST_READ);
    assign fl_wr = (state_q == ST_PROG);
    assign fl_erase = (state_q == ST_ERASE);
    // processor held while a go operation runs; reads do not stall
    assign cpu_stall = busy;

    default clocking dc @(posedge mclk); endclocking
    default disable iff (!rstn);

    sequence arm_then_quiet;
        arm_wr ##1 (!cmd_wr) [*4];
    endsequence

    go_needs_arm_a: assert property (idle && go_wr && !arm_live |=> !go_q && idle)
        else $error("go accepted without arm");
    arm_window_a: assert property (arm_then_quiet |=> !arm_live)
        else $error("arm window longer than four cycles");
    // read data in cache two cycles on
    read_lat_a: assert property (start_rd |=> fl_rd ##1 (cif.word_we && cif.word_be == 4'hF))
        else $error("read data not loaded in two cycles");
    stall_go_a: assert property (go_q |-> cpu_stall)
        else $error("processor not stalled during operation");
    // status half untouched by data writes
    rsvd_half_a: assert property (fl_wr && ret_q == ST_CP_NEXT && fl_addr[7:0] == WORD_LAST
                                  |-> fl_wdata[31:16] == HALF_ONES)
        else $error("data write reached status bytes");
    // program word from cache at word address
    pf_word_a: assert property (start_go && op_pprog
                                |=> fl_wr && fl_addr == addr_q[14:2] && fl_wdata == cache_word)
        else $error("program flash word write wrong");
    pf_erase_a: assert property (start_go && op_perase
                                 |=> fl_erase && fl_addr == {addr_q[14:10], WORD_FIRST})
        else $error("program flash erase address wrong");
    go_clear_a: assert property (state_q == ST_DONE |=> !go_q && idle)
        else $error("go not cleared at completion");
    // continuous writes go straight to swap target
    cont_direct_a: assert property (fl_wr && job_q == JOB_EMU && cont_q
                                    |-> fl_addr == {swp_pg, tgt_q})
        else $error("continuous write off target");
    status_last_a: assert property (fl_wr && ret_q == ST_RETIRE |-> idx_last && !cont_q)
        else $error("status written before copy finished");
    // automatic erase hits the swap page
    swap_erase_a: assert property (fl_erase && job_q == JOB_EMU |-> fl_addr[12:8] == swp_pg)
        else $error("erase hit the current page");
endmodule

// ==== fec_pkg.sv ====
// Shared constants, register map and state types of the flash EEPROM emulation controller
package fec_pkg;
    // Register indices on the plain register port
    localparam logic [3:0] REG_ADDR_LO = 4'h0;
    localparam logic [3:0] REG_ADDR_HI = 4'h1;
    localparam logic [3:0] REG_DATA = 4'h2;
    localparam logic [3:0] REG_CMD = 4'h3;
    localparam logic [3:0] REG_CFG = 4'h4;
    localparam logic [3:0] REG_CACHE0 = 4'h5;
    localparam logic [3:0] REG_CACHE3 = 4'h8;
    localparam logic [3:0] REG_STAT = 4'h9;
    // Field positions
    localparam int CMD_ARM_BIT = 4;
    localparam int CMD_GO_BIT = 5;
    localparam int CMD_RG_BIT = 6;
    localparam int CFG_CONT_BIT = 0;
    localparam int CFG_LEAD_BIT = 1;
    localparam int CFG_TRAIL_BIT = 2;
    localparam int CFG_SIZE_LSB = 3;
    // Values after reset
    localparam logic [15:0] ADDR_RST = 16'h0000;
    localparam logic [7:0] CFG_RST = 8'h06;
    localparam logic [3:0] OP_RST = 4'h0;
    localparam logic [7:0] CACHE_RST = 8'hFF;
    // Arm window length in cycles
    localparam logic [2:0] ARM_CYCLES = 3'h4;
    // Operation select encodings
    localparam logic [2:0] OP_MODE_BYTE = 3'h0;
    localparam logic [2:0] OP_MODE_WORD = 3'h2;
    localparam logic [1:0] OP_PF_ERASE = 2'h1;
    localparam logic [1:0] OP_PF_PROG = 2'h2;
    // Page layout: status in the upper half of the last word of a page
    localparam logic [15:0] STAT_VALID = 16'hA5C3;
    localparam logic [15:0] STAT_RETIRED = 16'h0000;
    localparam logic [15:0] HALF_ONES = 16'hFFFF;
    localparam logic [31:0] WORD_ONES = 32'hFFFFFFFF;
    localparam logic [7:0] WORD_FIRST = 8'h00;
    localparam logic [7:0] WORD_LAST = 8'hFF;
    // First flash page of the emulation pairs
    localparam logic [4:0] EMU_BASE_PAGE = 5'h18;

    typedef enum logic [4:0] {
        ST_BOOT_RD = 5'b00000,
        ST_BOOT_CHK = 5'b00001,
        ST_IDLE = 5'b00010,
        ST_EMU_GO = 5'b00011,
        ST_MRG_RD = 5'b00100,
        ST_MRG_CAP = 5'b00101,
        ST_ERASE = 5'b00110,
        ST_CP_SEL = 5'b00111,
        ST_CP_RD1 = 5'b01000,
        ST_CP_RD2 = 5'b01001,
        ST_CP_CHK = 5'b01010,
        ST_CP_NEXT = 5'b01011,
        ST_RETIRE = 5'b01100,
        ST_PROG = 5'b01101,
        ST_WAIT = 5'b01110,
        ST_DONE = 5'b01111,
        ST_READ = 5'b10000,
        ST_RD_CAP = 5'b10001
    } fec_state_t;

    typedef enum logic [0:0] {
        JOB_EMU = 1'b0,
        JOB_PF = 1'b1
    } fec_job_t;
endpackage

// ==== fec_cache_if.sv ====
// Signals between the controller and its word cache
`timescale 1ns/100ps
interface fec_cache_if;
    logic word_we;
    logic [3:0] word_be;
    logic [31:0] word_wd;
    logic byte_we;
    logic [1:0] byte_idx;
    logic [7:0] byte_wd;
    logic [31:0] word_q;

    modport ctrl (output word_we, output word_be, output word_wd, output byte_we,
                  output byte_idx, output byte_wd, input word_q);
    modport store (input word_we, input word_be, input word_wd, input byte_we,
                   input byte_idx, input byte_wd, output word_q);
endinterface

// ==== fec_word_cache.sv ====
// Four-byte word cache with byte and masked word loading
`timescale 1ns/100ps
module fec_word_cache
    import fec_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    fec_cache_if.store cif
);
    genvar i;
    generate
        for (i = 0; i < 4; i++)
        begin : g_byte
            logic [7:0] byte_q;
            // Word load from flash wins over a software byte write
            always_ff @(posedge mclk)
            begin
                if (!rstn)
                    byte_q <= CACHE_RST;
                else if (cif.word_we && cif.word_be[i])
                    byte_q <= cif.word_wd[8*i +: 8];
                else if (cif.byte_we && (cif.byte_idx == i))
                    byte_q <= cif.byte_wd;
            end
            assign cif.word_q[8*i +: 8] = byte_q;
        end
    endgenerate
endmodule

// ==== fec_flash_model.sv ====
// Behavioural page-erased flash array on the far side of the controller
`timescale 1ns/100ps
module fec_flash_model
    import fec_pkg::*;
(
    input wire logic mclk,
    input wire logic slow,
    input wire logic [12:0] fl_addr,
    input wire logic [31:0] fl_wdata,
    input wire logic fl_rd,
    input wire logic fl_wr,
    input wire logic fl_erase,
    output logic [31:0] fl_rdata,
    output logic fl_done
);
    logic [31:0] mem [0:8191];
    logic [3:0] wait_q = 4'h0;
    initial
    begin
        fl_rdata = 32'h0;
        fl_done = 1'b0;
        foreach (mem[i]) mem[i] = WORD_ONES;
    end
    // Programming only clears bits; the data bus toggles when not read
    always @(posedge mclk)
    begin
        fl_done <= (wait_q == 4'h1);
        fl_rdata <= fl_rd ? mem[fl_addr] : ~fl_rdata;
        if (fl_wr)
            mem[fl_addr] <= mem[fl_addr] & fl_wdata;
        if (fl_erase)
            for (int i = 0; i < 256; i++)
                mem[{fl_addr[12:8], 8'(i)}] <= WORD_ONES;
        if (fl_wr || fl_erase)
            wait_q <= slow ? 4'h6 : 4'h1;
        else if (wait_q != 4'h0)
            wait_q <= wait_q - 4'h1;
    end
endmodule

// ==== tb.sv ====
// Self-checking bench for the flash EEPROM emulation controller
`timescale 1ns/100ps
module tb
    import fec_pkg::*;
;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic slow = 1'b0;
    logic [7:0] reg_rdata, b;
    logic [12:0] fl_addr, lwa, lea;
    logic [31:0] fl_wdata, fl_rdata, lwd, w;
    logic fl_rd, fl_wr, fl_erase, fl_done, cpu_stall;
    int nwr = 0, ner = 0, n, e, mismatches = 0, checks = 0;
    always #10 mclk = ~mclk;
    fec_flash_eeprom_ctrl u_dut (.mclk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .fl_addr, .fl_wdata, .fl_rd, .fl_wr, .fl_erase, .fl_rdata, .fl_done,
        .cpu_stall);
    fec_flash_model u_flash (.mclk, .slow, .fl_addr, .fl_wdata, .fl_rd, .fl_wr, .fl_erase,
        .fl_rdata, .fl_done);
    always @(posedge mclk)
    begin
        if (fl_wr)
            {nwr, lwa, lwd} = {nwr + 1, fl_addr, fl_wdata};
        if (fl_erase)
            {ner, lea} = {ner + 1, fl_addr};
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        b = reg_rdata;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic setaddr(input logic [15:0] a);
        wr(REG_ADDR_LO, a[7:0]);
        wr(REG_ADDR_HI, a[15:8]);
    endtask
    task automatic wrw(input logic [31:0] d);
        for (int i = 0; i < 4; i++)
            wr(REG_CACHE0 + 4'(i), d[8*i +: 8]);
    endtask
    task automatic rdw();
        for (int i = 0; i < 4; i++)
        begin
            rd(REG_CACHE0 + 4'(i));
            w[8*i +: 8] = b;
        end
    endtask
    task automatic wait_idle();
        @(negedge mclk);
        for (int k = 0; k < 20000 && cpu_stall !== 1'b0; k++)
            @(negedge mclk);
        if (cpu_stall !== 1'b0)
        begin
            mismatches++;
            $display("wrong value at %0t: stall did not end", $time);
        end
    endtask
    task automatic run(input logic [3:0] op);
        wr(REG_CMD, {4'h1, op});
        wr(REG_CMD, {4'h2, op});
        wait_idle();
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (60000) @(posedge mclk);
        mismatches++;
        complete_run();
    end
    initial
    begin
        repeat (16) @(posedge mclk);
        rstn <= 1'b1;
        wait_idle();
        rd(REG_STAT);
        chk(b, 8'h4F);
        rd(REG_CFG);
        chk(b, CFG_RST);
        rd(4'hF);
        chk(b, 8'h00);
        rdw();
        chk(w, 32'hFFFFFFFF);
        setaddr(16'h0403);
        rd(REG_ADDR_HI);
        chk(b, 8'h04);
        $display("registers done");
        wrw(32'h11223344);
        wr(REG_CMD, 8'h2A);
        wr(REG_CMD, 8'h1A);
        repeat (4) @(posedge mclk);
        wr(REG_CMD, 8'h2A);
        wait_idle();
        chk(nwr, 0);
        slow = 1'b1;
        wr(REG_CMD, 8'h1A);
        wr(REG_CMD, 8'h2A);
        rd(REG_CMD);
        chk({b[5], cpu_stall}, 2'b11);
        wait_idle();
        rd(REG_CMD);
        chk(b[5], 1'b0);
        chk({lwa, lwd}, {13'h0100, 32'h11223344});
        chk(u_flash.mem[13'h0100], 32'h11223344);
        setaddr(16'h0407);
        run(4'hE);
        chk({nwr, lwa}, {32'd2, 13'h0101});
        for (int k = 0; k < 2; k++)
        begin
            u_flash.mem[13'h0200 + 13'(k * 256)] = 32'h0;
            setaddr(16'(16'h0800 + k * 16'h0400));
            run(k ? 4'h9 : 4'hD);
            chk({ner, lea[12:8]}, {k + 1, 5'(k + 2)});
            chk(u_flash.mem[13'h0200 + 13'(k * 256)], WORD_ONES);
            run(4'hA);
            chk(u_flash.mem[13'h0200 + 13'(k * 256)], 32'h11223344);
        end
        $display("program flash done");
        slow = 1'b0;
        u_flash.mem[13'h1900] = 32'h0000AAAA;
        u_flash.mem[13'h1905] = 32'h12345678;
        u_flash.mem[13'h1800] = 32'h0;
        setaddr(16'h0008);
        wrw(32'hCAFEBABE);
        run(4'h4);
        chk(u_flash.mem[13'h1800], 32'h0000AAAA);
        chk(u_flash.mem[13'h1802], 32'hCAFEBABE);
        chk(u_flash.mem[13'h1805], 32'h12345678);
        chk({u_flash.mem[13'h18FF], u_flash.mem[13'h19FF]}, 64'hA5C3FFFF0000FFFF);
        rd(REG_STAT);
        chk(b, 8'h4E);
        wrw(32'h0);
        wr(REG_CMD, 8'h44);
        repeat (2) @(posedge mclk);
        rdw();
        chk(w, 32'hCAFEBABE);
        $display("emulated word done");
        wr(REG_CFG, 8'h07);
        setaddr(16'h000C);
        wrw(32'h1);
        {n, e} = {nwr, ner};
        run(4'h4);
        chk({nwr - n, ner - e}, {32'd1, 32'd1});
        rd(REG_STAT);
        chk(b, 8'h4E);
        wr(REG_CFG, 8'h06);
        setaddr(16'h0010);
        wrw(32'h2);
        run(4'h4);
        chk(ner - e, 1);
        chk({u_flash.mem[13'h1903], u_flash.mem[13'h1904]}, 64'h0000000100000002);
        chk(u_flash.mem[13'h1902], 32'hCAFEBABE);
        chk(u_flash.mem[13'h19FF], 32'hA5C3FFFF);
        $display("continuous done");
        setaddr(16'h03FE);
        wr(REG_DATA, 8'h77);
        n = nwr;
        run(4'h0);
        chk(nwr - n, 0);
        setaddr(16'h0009);
        wr(REG_DATA, 8'h55);
        run(4'h0);
        chk(u_flash.mem[13'h1802], 32'hCAFE55BE);
        wr(REG_CMD, 8'h40);
        repeat (2) @(posedge mclk);
        rd(REG_DATA);
        chk(b, 8'h55);
        $display("byte mode done");
        complete_run();
    end
endmodule
